/* placeholder_none.v */
`timescale 1ns/1ps
// empty

/* sicb_bus_partner.sv */
// sicb_bus_partner: bus arbiter and memory answering the dma master
`timescale 1ns/1ps
module sicb_bus_partner (
	input wire         hclk,
	input wire         hresetn,
	input wire         bus_request_n,
	input wire         mst_ds_n,
	input wire         mst_write,
	input wire         slow,
	input wire         drop,
	output reg         bus_grant_n,
	output wire [15:0] ad_in,
	output wire        wait_rdy_in
);
	reg        wt_ff;
	reg [15:0] cnt_ff;
	// grant follows request; drop withdraws it mid-transfer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_grant_n <= 1'b1;
			wt_ff <= 1'b0;
			cnt_ff <= 16'h0000;
		end else begin
			bus_grant_n <= bus_request_n | drop;
			wt_ff <= ~mst_ds_n;
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end
	// wait sense: one low cycle per data phase when slow
	assign wait_rdy_in = ~(slow & ~mst_ds_n & ~wt_ff);
	// undriven bus shows a moving pattern, not a held value
	assign ad_in = (~mst_ds_n & ~mst_write) ? 16'h3C3C : cnt_ff;
endmodule // sicb_bus_partner

/* sicb_checker.sv */
// sicb_checker: chain, vector and bus-master timing assertions
`timescale 1ns/1ps
module sicb_checker (
	input wire        hclk,
	input wire        hresetn,
	input wire        chain_enable_in,
	input wire        chain_enable_out,
	input wire        int_n,
	input wire        int_acknowledge,
	input wire        bus_request_n,
	input wire        bus_grant_n,
	input wire [15:0] ad_out,
	input wire        ad_oe,
	input wire        mst_as_n,
	input wire [3:0]  dma_done
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_int_chain; !int_n |-> chain_enable_in; endproperty
	a_int_chain: assert property (p_int_chain)
		else $error("int request with chain input low");
	property p_chain_pass; !chain_enable_in |-> !chain_enable_out; endproperty
	a_chain_pass: assert property (p_chain_pass)
		else $error("chain output high while chain input low");
	property p_req_blk; !int_n |-> !chain_enable_out; endproperty
	a_req_blk: assert property (p_req_blk)
		else $error("chain output high while requesting");
	property p_as_grant; !mst_as_n |-> !$past(bus_grant_n); endproperty
	a_as_grant: assert property (p_as_grant)
		else $error("address strobe without grant");
	property p_as_drive; !mst_as_n |-> ad_oe; endproperty
	a_as_drive: assert property (p_as_drive)
		else $error("address phase not driven");
	property p_done_pulse; (dma_done != 4'h0) |=> (dma_done == 4'h0); endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("transfer done longer than one cycle");
	property p_vec_dup; ad_oe && bus_request_n |-> ad_out[15:8] == ad_out[7:0]; endproperty
	a_vec_dup: assert property (p_vec_dup)
		else $error("vector halves differ");
	property p_vec_ack; $rose(ad_oe) && bus_request_n |-> int_acknowledge; endproperty
	a_vec_ack: assert property (p_vec_ack)
		else $error("vector driven without acknowledge");
endmodule // sicb_checker
bind sicb_core sicb_checker u_chk (.hclk, .hresetn, .chain_enable_in, .chain_enable_out,
	.int_n, .int_acknowledge, .bus_request_n, .bus_grant_n, .ad_out, .ad_oe, .mst_as_n,
	.dma_done);

/* sicb_core.v */
// sicb_core: interrupt chain, polling flags and four-channel dma bus master
`timescale 1ns/1ps
`include "sicb_regs.vh"
module sicb_core #(
	parameter CW = 16
) (
	input  wire          hclk,
	input  wire          hresetn,
	input  wire          clk_en,
	input  wire          hsel,
	input  wire [31:0]   haddr,
	input  wire [1:0]    htrans,
	input  wire          hwrite,
	input  wire [2:0]    hsize,
	input  wire          hready,
	input  wire [31:0]   hwdata,
	output wire [31:0]   hrdata,
	output wire          hreadyout,
	output wire          hresp,
	input  wire [1:0]    rx_char,
	input  wire [1:0]    rx_overrun,
	input  wire [1:0]    rx_frame_err,
	input  wire [1:0]    rx_eof,
	input  wire [1:0]    rx_parity_err,
	input  wire [1:0]    tx_empty,
	input  wire [1:0]    cts_n,
	input  wire [1:0]    dcd_n,
	input  wire [1:0]    sync_n,
	input  wire [1:0]    tx_underrun,
	input  wire [1:0]    baud_zero,
	input  wire [1:0]    break_abort,
	input  wire [1:0]    end_of_poll,
	input  wire [1:0]    rx_dma_req,
	input  wire [1:0]    tx_dma_req,
	input  wire [15:0]   rx_dma_byte,
	input  wire          chain_enable_in,
	output wire          chain_enable_out,
	output wire          int_n,
	input  wire          int_acknowledge,
	output wire          bus_request_n,
	input  wire          bus_grant_n,
	input  wire [15:0]   ad_in,
	output wire [15:0]   ad_out,
	output wire          ad_oe,
	output wire          mst_as_n,
	output wire          mst_ds_n,
	output wire          mst_write,
	input  wire          wait_rdy_in,
	input  wire          slave_sel,
	output wire          wait_rdy_out,
	output wire          wait_rdy_oe,
	output wire [7:0]    dma_tx_byte,
	output wire [3:0]    dma_done
);
	localparam NS = 10;
	localparam NSC = 6;
	localparam ST_IDL = 3'h0;
	localparam ST_REQ = 3'h1;
	localparam ST_NXT = 3'h2;
	localparam ST_UPR = 3'h3;
	localparam ST_LWR = 3'h4;
	localparam ST_DAT = 3'h5;

	reg  [7:0]      a_ff;
	reg             w_ff;
	reg  [31:0]     hrdata_ff;
	reg  [31:0]     rd;
	reg  [7:0]      ctrl_ff;
	reg  [10:0]     scie_ff;
	reg  [11:0]     dmie_ff;
	reg  [15:0]     vec_ff;
	reg  [5:0]      ev_ff;
	reg  [NS-1:0]   ip_ff;
	reg  [NS-1:0]   ius_ff;
	reg  [3:0]      tcf_ff;
	reg  [3:0]      abf_ff;
	reg  [15:0]     pv_ff;
	reg  [1:0]      fst_ff;
	reg  [1:0]      spc_ff;
	reg  [127:0]    adr_ff;
	reg  [4*CW-1:0] cnt_ff;
	reg  [3:0]      dir_ff;
	reg             ack_d_ff;
	reg             dbl_ff;
	reg             vld_ff;
	reg  [7:0]      vout_ff;
	reg  [2:0]      st_ff;
	reg  [1:0]      cur_ff;
	reg  [3:0]      msk_ff;
	reg             breq_ff;
	reg  [15:0]     ad_ff;
	reg             adoe_ff;
	reg             as_n_ff;
	reg             ds_n_ff;
	reg             mw_ff;
	reg  [7:0]      txb_ff;
	reg  [3:0]      done_ff;
	reg             fnd;
	reg             any;
	reg  [3:0]      win;
	reg  [7:0]      vsel;
	reg  [1:0]      sidx;
	reg  [1:0]      dch;
	reg  [1:0]      tcode;
	reg  [1:0]      enc;
	integer         i;
	wire [5:0]      sc_set;
	wire [5:0]      pev;
	wire [3:0]      nz;
	wire [3:0]      step;
	wire [3:0]      tc_ev;
	wire [3:0]      ab_ev;

	wire take_ap = hsel & hready & htrans[1];
	wire wr_ctrl = w_ff & (a_ff == `S_A_CTRL);
	wire wr_scie = w_ff & (a_ff == `S_A_SCIE);
	wire wr_dmie = w_ff & (a_ff == `S_A_DMIE);
	wire wr_vec = w_ff & (a_ff == `S_A_VEC);
	wire wr_cmd = w_ff & (a_ff == `S_A_CMD);
	wire [NS-1:0] ipc = wr_cmd ? hwdata[`S_M_IPC +: NS] : {NS{1'b0}};
	wire [5:0] evc = wr_cmd ? hwdata[`S_M_EVC +: 6] : 6'h00;
	wire eoi = wr_cmd & hwdata[`S_M_EOI];
	wire [1:0] ackm = ctrl_ff[`S_C_ACK +: 2];
	wire wrs = ctrl_ff[`S_C_WRS];
	wire [3:0] dreq = {tx_dma_req[1], rx_dma_req[1], tx_dma_req[0], rx_dma_req[0]}; // see [RULE_17]
	wire [3:0] elig = dreq & dmie_ff[`S_D_EN +: 4] & nz;
	wire [3:0] hi = elig & (~elig + 4'h1); // see [RULE_16]
	wire [3:0] pm = msk_ff & elig;
	wire [3:0] pk = pm & (~pm + 4'h1);
	wire granted = ~bus_grant_n;
	wire mst = (st_ff != ST_IDL) && (st_ff != ST_REQ);
	wire wt = wrs ? wait_rdy_in : ~wait_rdy_in; // see [RULE_22]
	wire [3:0] dm_en = (tcf_ff & dmie_ff[`S_D_TC +: 4]) | (abf_ff & dmie_ff[`S_D_AB +: 4]);
	wire [NS-1:0] en_eff = {dm_en, scie_ff[`S_I_IE +: NSC]};
	wire [NS-1:0] master_int_enable = {{4{ctrl_ff[`S_C_DMM]}}, {NSC{ctrl_ff[`S_C_SCM]}}};
	wire [NS-1:0] req = ip_ff & en_eff & master_int_enable; // see [RULE_03]
	wire int_req = any & chain_enable_in; // see [RULE_05]
	wire arise = int_acknowledge & ~ack_d_ff;
	wire afall = ~int_acknowledge & ack_d_ff;
	wire take = arise & ((ackm != `S_ACK_DBL) | dbl_ff); // see [RULE_21]
	wire [NS-1:0] ius_top = ius_ff & (~ius_ff + 10'h001);
	wire [NS-1:0] ius_set = (take & int_req) ? (10'h001 << win) : {NS{1'b0}}; // see [RULE_08]
	wire notrdy = int_acknowledge & ~vld_ff;

	// zero wait states; a frozen clock enable stalls the bus rather than losing a transfer
	assign hreadyout = clk_en;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign int_n = ~int_req;
	assign chain_enable_out = chain_enable_in & ~(|ius_ff) & ~any; // see [RULE_07]
	assign bus_request_n = ~breq_ff; // see [RULE_19]
	assign ad_out = mst ? ad_ff : {vout_ff, vout_ff};
	assign ad_oe = mst ? adoe_ff : vld_ff;
	assign mst_as_n = as_n_ff;
	assign mst_ds_n = ds_n_ff;
	assign mst_write = mw_ff;
	assign wait_rdy_out = wrs ? notrdy : ~notrdy; // see [RULE_22]
	assign wait_rdy_oe = (slave_sel | int_acknowledge) & ~mst;
	assign dma_tx_byte = txb_ff;
	assign dma_done = done_ff;
	assign step = (st_ff == ST_DAT && granted && !wt) ? (4'h1 << cur_ff) : 4'h0;
	assign ab_ev = (mst && st_ff != ST_NXT && !granted) ? (4'h1 << cur_ff) : 4'h0; // see [RULE_15]

	always @* begin
		rd = 32'h00000000;
		case (haddr[7:0])
			`S_A_CTRL: rd[7:0] = ctrl_ff;
			`S_A_DMIE: rd[11:0] = dmie_ff; // see [RULE_04]
			`S_A_VEC: rd[15:0] = vec_ff;
			`S_A_STAT: rd = {6'h00, ev_ff, ius_ff, ip_ff}; // see [RULE_01]
			default: begin
				if (haddr[7:5] == `S_A_CH && haddr[`S_CH_CNT]) begin
					rd[CW-1:0] = cnt_ff[haddr[4:3]*CW +: CW];
					rd[`S_K_DIR] = dir_ff[haddr[4:3]];
				end else if (haddr[7:5] == `S_A_CH) begin
					rd = adr_ff[haddr[4:3]*32 +: 32];
				end
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_ff <= 8'h00;
			w_ff <= 1'b0;
			hrdata_ff <= 32'h00000000;
		end else if (clk_en) begin
			w_ff <= take_ap & hwrite;
			if (take_ap) a_ff <= haddr[7:0];
			hrdata_ff <= (take_ap & ~hwrite) ? rd : 32'h00000000;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sc
			wire [7:0] cur = {end_of_poll[g], break_abort[g], baud_zero[g], tx_underrun[g],
				sync_n[g], dcd_n[g], cts_n[g], tx_empty[g]};
			wire [7:0] rise = cur & ~pv_ff[g*8 +: 8];
			wire [7:0] fall = ~cur & pv_ff[g*8 +: 8];
			wire [1:0] rm = scie_ff[`S_I_RMA + 2*g +: 2];
			wire sp = rx_overrun[g] | rx_frame_err[g] | rx_eof[g]
				| (ctrl_ff[`S_C_PAR] & rx_parity_err[g]); // see [RULE_12]
			wire rx_ev = ((rm != `S_RX_OFF) & sp) | ((rm == `S_RX_ALL) & rx_char[g])
				| ((rm == `S_RX_FST) & rx_char[g] & fst_ff[g]); // see [RULE_11]
			// empty rises only after a write has dropped it, so a never-loaded buffer stays quiet
			wire tx_ev = rise[0]; // see [RULE_10]
			wire ex_ev = (|(rise[3:1] | fall[3:1])) | (|rise[7:4])
				| (scie_ff[`S_I_ABE] & (fall[6] | fall[7])); // see [RULE_13] see [RULE_14]
			assign sc_set[g*3 +: 3] = {ex_ev, tx_ev, rx_ev};
			assign pev[g*3 +: 3] = {ex_ev, tx_ev, rx_char[g] | sp};
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pv_ff[g*8 +: 8] <= `S_PV_RST;
					fst_ff[g] <= 1'b0;
					spc_ff[g] <= 1'b0;
				end else if (clk_en) begin
					pv_ff[g*8 +: 8] <= cur;
					if (wr_scie) fst_ff[g] <= 1'b1;
					else if (rm == `S_RX_FST && rx_char[g]) fst_ff[g] <= 1'b0;
					if (rx_ev) spc_ff[g] <= sp;
				end
			end
		end
		for (g = 0; g < 4; g = g + 1) begin : g_dm
			wire wch = w_ff & (a_ff[7:5] == `S_A_CH) & (a_ff[4:3] == g);
			assign nz[g] = |cnt_ff[g*CW +: CW];
			assign tc_ev[g] = step[g] & (cnt_ff[g*CW +: CW] == {{(CW-1){1'b0}}, 1'b1});
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					adr_ff[g*32 +: 32] <= 32'h00000000;
					cnt_ff[g*CW +: CW] <= {CW{1'b0}};
					dir_ff[g] <= 1'b0;
				end else if (clk_en) begin
					if (wch && !a_ff[`S_CH_CNT]) adr_ff[g*32 +: 32] <= hwdata;
					else if (step[g] && dir_ff[g]) adr_ff[g*32 +: 32] <= adr_ff[g*32 +: 32] - 32'h1;
					else if (step[g]) adr_ff[g*32 +: 32] <= adr_ff[g*32 +: 32] + 32'h1; // see [RULE_18]
					if (wch && a_ff[`S_CH_CNT]) begin
						cnt_ff[g*CW +: CW] <= hwdata[CW-1:0];
						dir_ff[g] <= hwdata[`S_K_DIR];
					end else if (step[g]) begin
						cnt_ff[g*CW +: CW] <= cnt_ff[g*CW +: CW] - {{(CW-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	endgenerate

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `S_CTRL_RST;
			scie_ff <= 11'h000;
			dmie_ff <= 12'h000;
			vec_ff <= 16'h0000;
			ev_ff <= 6'h00;
			ip_ff <= {NS{1'b0}};
			ius_ff <= {NS{1'b0}};
			tcf_ff <= 4'h0;
			abf_ff <= 4'h0;
		end else if (clk_en) begin
			if (wr_ctrl) ctrl_ff <= hwdata[7:0];
			if (wr_scie) scie_ff <= hwdata[10:0];
			if (wr_dmie) dmie_ff <= hwdata[11:0];
			else dmie_ff[`S_D_EN +: 4] <= dmie_ff[`S_D_EN +: 4] & ~tc_ev;
			if (wr_vec) vec_ff <= hwdata[15:0];
			ev_ff <= (ev_ff & ~evc) | pev; // see [RULE_01]
			ip_ff[NSC-1:0] <= (ip_ff[NSC-1:0] & ~ipc[NSC-1:0])
				| (sc_set & scie_ff[`S_I_IE +: NSC]); // see [RULE_06]
			ip_ff[NS-1:NSC] <= (ip_ff[NS-1:NSC] & ~ipc[NS-1:NSC]) | tc_ev | ab_ev; // see [RULE_06]
			tcf_ff <= (tcf_ff & ~ipc[NS-1:NSC]) | tc_ev; // see [RULE_15]
			abf_ff <= (abf_ff & ~ipc[NS-1:NSC]) | ab_ev;
			ius_ff <= (ius_ff & ~(eoi ? ius_top : {NS{1'b0}})) | ius_set;
		end
	end

	// index order is the priority order, so the first under-service bit met ends the walk
	always @* begin
		fnd = 1'b0;
		any = 1'b0;
		win = 4'h0;
		for (i = 0; i < NS; i = i + 1) begin
			if (!fnd && ius_ff[i]) begin
				fnd = 1'b1; // see [RULE_07]
			end else if (!fnd && req[i]) begin
				fnd = 1'b1;
				any = 1'b1;
				win = i[3:0]; // see [RULE_09]
			end
		end
	end

	always @* begin
		sidx = (win >= 4'h3) ? win[1:0] - 2'h3 : win[1:0];
		dch = win[1:0] + 2'h2;
		tcode = (sidx == 2'h1) ? `S_T_TX : (sidx == 2'h2) ? `S_T_EX : `S_T_RX;
		if (sidx == 2'h0 && spc_ff[win >= 4'h3]) tcode = `S_T_SP; // see [RULE_12]
		vsel = vec_ff[`S_V_SC +: 8];
		if (win >= NSC) begin
			vsel = vec_ff[`S_V_DM +: 8];
			if (ctrl_ff[`S_C_VMD]) vsel[2:0] = {dch, abf_ff[dch]};
		end else if (ctrl_ff[`S_C_VMD]) begin
			vsel[3:1] = {win < 4'h3, tcode}; // see [RULE_02]
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_d_ff <= 1'b0;
			dbl_ff <= 1'b0;
			vld_ff <= 1'b0;
			vout_ff <= 8'h00;
		end else if (clk_en) begin
			ack_d_ff <= int_acknowledge;
			if (ackm != `S_ACK_DBL) dbl_ff <= 1'b0;
			else if (arise) dbl_ff <= ~dbl_ff; // see [RULE_21]
			if (take && int_req) begin
				vld_ff <= 1'b1;
				vout_ff <= vsel; // see [RULE_02]
			end else if (afall) begin
				vld_ff <= 1'b0;
			end
		end
	end

	always @* begin
		enc = 2'h0;
		if (pk[1]) enc = 2'h1;
		if (pk[2]) enc = 2'h2;
		if (pk[3]) enc = 2'h3;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= ST_IDL;
			cur_ff <= 2'h0;
			msk_ff <= 4'h0;
			breq_ff <= 1'b0;
			ad_ff <= 16'h0000;
			adoe_ff <= 1'b0;
			as_n_ff <= 1'b1;
			ds_n_ff <= 1'b1;
			mw_ff <= 1'b0;
			txb_ff <= 8'h00;
			done_ff <= 4'h0;
		end else if (clk_en) begin
			done_ff <= 4'h0;
			case (st_ff)
				ST_IDL: begin
					if (|elig) begin
						breq_ff <= 1'b1; // see [RULE_19]
						st_ff <= ST_REQ;
					end
				end
				ST_REQ: begin
					if (granted) begin
						msk_ff <= ctrl_ff[`S_C_PCH] ? hi : elig; // see [RULE_20]
						st_ff <= ST_NXT;
					end
				end
				ST_NXT, ST_UPR, ST_LWR, ST_DAT: begin
					if (!granted) begin
						// grant lost: stop at once; outside ST_NXT the abort was flagged by the same edge, in ST_NXT none is
						st_ff <= ST_IDL;
						breq_ff <= 1'b0;
						adoe_ff <= 1'b0;
						as_n_ff <= 1'b1;
						ds_n_ff <= 1'b1;
						msk_ff <= 4'h0;
					end else if (st_ff == ST_NXT && |pm) begin
						msk_ff <= pm;
						cur_ff <= enc;
						ad_ff <= adr_ff[enc*32 + 16 +: 16]; // see [RULE_22]
						adoe_ff <= 1'b1;
						as_n_ff <= 1'b0;
						mw_ff <= ~enc[0];
						st_ff <= ST_UPR;
					end else if (st_ff == ST_NXT) begin
						msk_ff <= 4'h0;
						breq_ff <= 1'b0; // see [RULE_19]
						st_ff <= ST_IDL;
					end else if (st_ff == ST_UPR) begin
						ad_ff <= adr_ff[cur_ff*32 +: 16];
						st_ff <= ST_LWR;
					end else if (st_ff == ST_LWR) begin
						as_n_ff <= 1'b1;
						ds_n_ff <= 1'b0;
						ad_ff <= {2{rx_dma_byte[cur_ff[1]*8 +: 8]}};
						adoe_ff <= mw_ff;
						st_ff <= ST_DAT;
					end else if (!wt) begin
						ds_n_ff <= 1'b1;
						adoe_ff <= 1'b0;
						done_ff <= step;
						if (!mw_ff) txb_ff <= ad_in[7:0];
						st_ff <= ST_NXT;
					end
				end
				default: begin
					st_ff <= ST_IDL;
					breq_ff <= 1'b0;
				end
			endcase
		end
	end
endmodule // sicb_core

/* sicb_regs.vh */
// sicb register map, field positions, codes and reset values
// How it works
// [RULE_01] poll status flags set by every event
// [RULE_02] acknowledge returns serial or dma vector
// [RULE_03] source requests need own and master enable
// [RULE_04] two master enables; serial enables write-only
// [RULE_05] int only with pending and chain input high
// [RULE_06] serial pending needs enable; dma pending not
// [RULE_07] under-service blocks lower sources, drops chain out
// [RULE_08] acknowledge sets under-service of chain winner only
// [RULE_09] serial over dma, a over b, rx-tx-ext
// [RULE_10] transmit empty after write raises request
// [RULE_11] three receive modes; specials after first char
// [RULE_12] special conditions differ only in vector status
// [RULE_13] modem edges and line events raise ext status
// [RULE_14] abort and end of poll at start and end
// [RULE_15] dma terminal count and abort share pending
// [RULE_16] dma order rx a, tx a, rx b, tx b
// [RULE_17] dma requests wired to receivers and transmitters
// [RULE_18] per-channel address step and length counter
// [RULE_19] request bus, move while granted and needed
// [RULE_20] per-channel tenure or serve all pending
// [RULE_21] acknowledge as level, pulse or double pulse
// [RULE_22] multiplexed address data, wait ready both ways
`ifndef SICB_REGS_VH
`define SICB_REGS_VH
`define S_A_CTRL 8'h00
`define S_A_SCIE 8'h04
`define S_A_DMIE 8'h08
`define S_A_VEC 8'h0C
`define S_A_STAT 8'h10
`define S_A_CMD 8'h14
`define S_A_CH 3'h1
`define S_CH_CNT 2
`define S_C_SCM 0
`define S_C_DMM 1
`define S_C_ACK 2
`define S_C_PCH 4
`define S_C_WRS 5
`define S_C_VMD 6
`define S_C_PAR 7
`define S_I_IE 0
`define S_I_RMA 6
`define S_I_ABE 10
`define S_D_TC 0
`define S_D_AB 4
`define S_D_EN 8
`define S_V_SC 0
`define S_V_DM 8
`define S_S_IUS 10
`define S_S_EV 20
`define S_M_IPC 0
`define S_M_EVC 16
`define S_M_EOI 24
`define S_K_DIR 16
`define S_ACK_LVL 2'h0
`define S_ACK_PLS 2'h1
`define S_ACK_DBL 2'h2
`define S_RX_OFF 2'h0
`define S_RX_FST 2'h1
`define S_RX_ALL 2'h2
`define S_T_TX 2'h0
`define S_T_EX 2'h1
`define S_T_RX 2'h2
`define S_T_SP 2'h3
`define S_CTRL_RST 8'h00
`define S_PV_RST 8'h0F
`endif

/* tb_top.sv */
// tb_top: register, interrupt and dma scenarios for sicb_core
`timescale 1ns/1ps
`include "sicb_regs.vh"
module tb_top;
	reg         hclk = 1'b0;
	reg         hresetn = 1'b0;
	reg         hsel = 1'b0;
	reg  [31:0] haddr = 32'h0;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'b0;
	reg  [31:0] hwdata = 32'h0;
	reg  [1:0]  rx_char = 2'h0;
	reg  [1:0]  cts_n = 2'h3;
	reg  [1:0]  rx_overrun = 2'h0;
	reg  [1:0]  rx_frame_err = 2'h0;
	reg  [1:0]  rx_eof = 2'h0;
	reg  [1:0]  rx_parity_err = 2'h0;
	reg  [1:0]  tx_empty = 2'h3;
	reg  [1:0]  dcd_n = 2'h3;
	reg  [1:0]  sync_n = 2'h3;
	reg  [1:0]  tx_underrun = 2'h0;
	reg  [1:0]  baud_zero = 2'h0;
	reg  [1:0]  break_abort = 2'h0;
	reg  [1:0]  end_of_poll = 2'h0;
	reg  [1:0]  rx_dma_req = 2'h0;
	reg  [1:0]  tx_dma_req = 2'h0;
	reg         chain_enable_in = 1'b1;
	reg         int_acknowledge = 1'b0;
	reg         slow = 1'b0;
	reg         drop = 1'b0;
	reg  [31:0] rd;
	integer     n_errors = 0;
	integer     checks = 0;
	integer     i;
	wire [31:0] hrdata;
	wire [15:0] ad_in;
	wire [15:0] ad_out;
	wire [7:0]  dma_tx_byte;
	wire [3:0]  dma_done;
	wire        hreadyout;
	wire        chain_enable_out;
	wire        int_n;
	wire        bus_request_n;
	wire        bus_grant_n;
	wire        ad_oe;
	wire        mst_as_n;
	wire        mst_ds_n;
	wire        mst_write;
	wire        wait_rdy_in;
	always #5 hclk = ~hclk;
	sicb_core dut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(),
		.rx_char, .rx_overrun, .rx_frame_err, .rx_eof,
		.rx_parity_err, .tx_empty, .cts_n, .dcd_n, .sync_n,
		.tx_underrun, .baud_zero, .break_abort, .end_of_poll,
		.rx_dma_req, .tx_dma_req, .rx_dma_byte(16'hA5A5), .chain_enable_in,
		.chain_enable_out, .int_n, .int_acknowledge, .bus_request_n, .bus_grant_n,
		.ad_in, .ad_out, .ad_oe, .mst_as_n, .mst_ds_n, .mst_write, .wait_rdy_in,
		.slave_sel(1'b0), .wait_rdy_out(), .wait_rdy_oe(), .dma_tx_byte, .dma_done);
	sicb_bus_partner u_bus (.hclk, .hresetn, .bus_request_n, .mst_ds_n, .mst_write,
		.slow, .drop, .bus_grant_n, .ad_in, .wait_rdy_in);
	task ahb(input w, input [31:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			htrans <= 2'h2;
			haddr <= a;
			hwrite <= w;
			do @(posedge hclk); while (hreadyout !== 1'b1);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			do @(posedge hclk); while (hreadyout !== 1'b1);
			rd = hrdata;
			@(posedge hclk);
		end
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task rdc(input [31:0] a, input [31:0] exp);
		begin
			ahb(1'b0, a, 32'h0);
			cmp(rd, exp);
		end
	endtask
	// bounded wait for the bus request level, then compared
	task wreq(input v);
		begin
			i = 0;
			do begin
				@(posedge hclk);
				i = i + 1;
			end while (bus_request_n !== v && i < 300);
			cmp({31'h0, bus_request_n}, {31'h0, v});
		end
	endtask
	task ack_vec(input [15:0] exp);
		begin
			int_acknowledge <= 1'b1;
			repeat (3) @(posedge hclk);
			cmp({15'h0, ad_oe, ad_out}, {15'h0, 1'b1, exp});
			cmp({31'h0, chain_enable_out}, 32'h0);
			int_acknowledge <= 1'b0;
			repeat (3) @(posedge hclk);
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks=%0d n_errors=%0d", checks, n_errors);
			if (n_errors == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		#200000;
		n_errors = n_errors + 1;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(`S_A_STAT, 32'h0);
		rdc(32'h0000_0018, 32'h0);
		// polling: everything disabled, flags still follow events
		rx_char <= 2'h1;
		cts_n <= 2'h1;
		@(posedge hclk);
		rx_char <= 2'h0;
		repeat (2) @(posedge hclk);
		rdc(`S_A_STAT, 32'h0210_0000);
		ahb(1'b1, `S_A_CMD, 32'h003F_0000);
		rdc(`S_A_STAT, 32'h0);
		ahb(1'b1, `S_A_SCIE, 32'h0000_02BF);
		rdc(`S_A_SCIE, 32'h0);
		ahb(1'b1, `S_A_DMIE, 32'h0000_00F0);
		rdc(`S_A_DMIE, 32'h0000_00F0);
		ahb(1'b1, `S_A_VEC, 32'h0000_C050);
		ahb(1'b1, `S_A_CTRL, 32'h0000_0001);
		rx_char <= 2'h3;
		@(posedge hclk);
		rx_char <= 2'h0;
		repeat (2) @(posedge hclk);
		rdc(`S_A_STAT, 32'h0090_0009);
		cmp({31'h0, int_n}, 32'h0);
		chain_enable_in <= 1'b0;
		repeat (2) @(posedge hclk);
		cmp({31'h0, int_n}, 32'h1);
		chain_enable_in <= 1'b1;
		ack_vec(16'h5050);
		rdc(`S_A_STAT, 32'h0090_0409);
		ahb(1'b1, `S_A_CMD, 32'h0100_0001);
		ahb(1'b1, `S_A_CTRL, 32'h0000_0041);
		ack_vec(16'h5454);
		ahb(1'b1, `S_A_CMD, 32'h013F_03FF);
		// rx channel a moves two bytes then stops at terminal count
		ahb(1'b1, 32'h0000_0020, 32'h0001_2340);
		ahb(1'b1, 32'h0000_0024, 32'h0000_0002);
		ahb(1'b1, `S_A_DMIE, 32'h0000_0101);
		ahb(1'b1, `S_A_CTRL, 32'h0000_0002);
		rx_dma_req <= 2'h1;
		wreq(1'b0);
		wreq(1'b1);
		rx_dma_req <= 2'h0;
		rdc(32'h0000_0020, 32'h0001_2342);
		rdc(32'h0000_0024, 32'h0);
		rdc(`S_A_DMIE, 32'h0000_0001);
		rdc(`S_A_STAT, 32'h0000_0040);
		// tx channel a with waits, grant withdrawn mid-block
		ahb(1'b1, `S_A_CMD, 32'h0000_03FF);
		ahb(1'b1, 32'h0000_002C, 32'h0000_0005);
		ahb(1'b1, `S_A_DMIE, 32'h0000_0220);
		slow <= 1'b1;
		tx_dma_req <= 2'h1;
		i = 0;
		do begin
			@(posedge hclk);
			i = i + 1;
		end while (dma_done[1] !== 1'b1 && i < 300);
		cmp({24'h0, dma_tx_byte}, 32'h0000_003C);
		drop <= 1'b1;
		wreq(1'b1);
		tx_dma_req <= 2'h0;
		drop <= 1'b0;
		ahb(1'b0, `S_A_STAT, 32'h0);
		cmp(rd & 32'h0000_0080, 32'h0000_0080);
		tally_and_finish;
	end
endmodule // tb_top
